// file: vsp_pkg.sv
// Shared constants, types and helpers of the video DRAM stop-point controller
package vsp_pkg;

    // Timing
    localparam int CLK_MHZ      = 50;
    localparam int T_PWRUP_US   = 200;
    localparam int PWRUP_CYC    = T_PWRUP_US * CLK_MHZ;
    localparam int T_STEP_NS    = 80;
    localparam int STEP_CYC     = (T_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_REFRESH = 8;
    localparam int INIT_SCLK    = 2;

    // Register offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_PART   = 8'h14;

    // Field positions
    localparam int ADDR_COL_LSB  = 16;
    localparam int ST_BUSY       = 0;
    localparam int ST_INIT       = 1;
    localparam int ST_STOP       = 2;
    localparam int ST_TAPERR     = 3;
    localparam int ST_RVALID     = 4;
    localparam int PART_AUTO     = 4;

    // Partition value after reset and partition length base
    localparam logic [4:0] PART_RST = 5'h13;
    localparam int PART_BASE_LOG2   = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_READ   = 3'h1,
        CMD_WRITE  = 3'h2,
        CMD_CBR    = 3'h3,
        CMD_SETUP  = 3'h4,
        CMD_FULLX  = 3'h5,
        CMD_SPLITX = 3'h6,
        CMD_RASREF = 3'h7
    } vsp_cmd_t;

    typedef struct packed {
        logic       ras_n;
        logic       cas_n;
        logic [1:0] write_strobes_n;
        logic       special_function_select;
        logic       transfer_output_enable_n;
        logic       serial_clock;
        logic [8:0] addr;
    } vsp_pins_t;

    // Partition mask: length is 2^(base+code), capped at a buffer half
    function automatic logic [7:0] part_mask(input logic [3:0] code);
        int lg;
        lg = PART_BASE_LOG2 + int'(code);
        if (lg > 7) begin
            lg = 7;
        end
        return 8'((1 << lg) - 1);
    endfunction

    // Column bits seven and eight exchanged while stop mode is on
    function automatic logic [8:0] col_map(input logic [8:0] c,
                                           input logic       stop);
        return stop ? {c[7], c[8], c[6:0]} : c;
    endfunction

endpackage

// file: vsp_buf2.sv
// Two-entry valid/ready buffer for write data
`timescale 1ns/1ps
module vsp_buf2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    logic [WIDTH-1:0] mem_q [2];
    logic             wp_q;
    logic             rp_q;
    logic [1:0]       cnt_q;
    logic             push;
    logic             pop;

    // Honest full and empty from the occupancy count
    assign in_ready_out  = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out  = mem_q[rp_q];
    assign push = ce_in && in_valid_in && in_ready_out;
    assign pop  = ce_in && out_ready_in && out_valid_out;

    // Storage
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem_q[wp_q] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end
endmodule

// file: vsp_ctrl.sv
// Host controller driving a video DRAM, with AXI4-Lite command registers
`timescale 1ns/1ps
module vsp_ctrl #(
    parameter int PWRUP_CYCLES = vsp_pkg::PWRUP_CYC
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [7:0]        s_axi_awaddr_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    output logic [1:0]             s_axi_bresp_out,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    input  wire logic [7:0]        s_axi_araddr_in,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output vsp_pkg::vsp_pins_t     dram_pins_out,
    input  wire logic [15:0]       dq_in,
    output logic [15:0]            dq_out,
    output logic                   dq_oe_n_out
);
    import vsp_pkg::*;

    typedef enum logic [7:0] {
        S_PWR  = 8'h01,
        S_IDLE = 8'h02,
        S_ADDR = 8'h04,
        S_ROW  = 8'h08,
        S_COL  = 8'h10,
        S_PRE  = 8'h20,
        S_CBRC = 8'h40,
        S_SCLK = 8'h80
    } vsp_state_t;

    vsp_state_t state_q;
    vsp_cmd_t   cmd_q;
    vsp_cmd_t   pend_q;
    logic [13:0] pwr_q;
    logic [2:0]  step_q;
    logic [3:0]  ref_cnt_q;
    logic [1:0]  init_ph_q;
    logic        init_done_q;
    logic        sclk_cnt_q;
    logic        stop_q;
    logic        tap_err_q;
    logic        rvalid_flag_q;
    logic [31:0] addr_q;
    logic [4:0]  part_q;
    logic [15:0] rd_q;
    logic [15:0] wd_q;
    logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;
    vsp_pins_t   pins_d, pins_q;
    logic        dq_oe_n_d, dq_oe_n_q;
    logic        bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        wr_go, rd_go, cmd_wr, step_end, busy, take_wd;
    logic        buf_in_ready, buf_out_valid;
    logic [15:0] buf_out_data;
    logic        reg_hit_w, reg_hit_r;
    vsp_cmd_t    sw_cmd;
    logic [7:0]  tap_mask;
    logic        tap_bad;

    // Write data waits here; a full buffer stalls the bus write
    vsp_buf2 #(.WIDTH(16)) u_buf (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .ce_in         (ce_in),
        .in_valid_in   (wr_go && s_axi_awaddr_in == REG_WDATA),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (s_axi_wdata_in[15:0]),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (take_wd),
        .out_data_out  (buf_out_data)
    );

    // Bus decode; address and data taken together
    assign reg_hit_w = s_axi_awaddr_in inside {REG_CMD, REG_ADDR, REG_WDATA,
                                               REG_STATUS, REG_PART};
    assign reg_hit_r = s_axi_araddr_in inside {REG_CMD, REG_ADDR, REG_STATUS,
                                               REG_RDATA, REG_PART};
    assign wr_go = ce_in && s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q
                   && (s_axi_awaddr_in != REG_WDATA || buf_in_ready);
    assign rd_go = ce_in && s_axi_arvalid_in && !rvalid_q;
    assign s_axi_awready_out = wr_go;
    assign s_axi_wready_out  = wr_go;
    assign s_axi_arready_out = rd_go;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;

    // Command acceptance; a split tap on a stop point is refused
    assign sw_cmd   = vsp_cmd_t'(s_axi_wdata_in[2:0]);
    assign tap_mask = part_mask(part_q[3:0]);
    assign tap_bad  = stop_q && sw_cmd == CMD_SPLITX
                      && (addr_q[ADDR_COL_LSB +: 8] & tap_mask) == tap_mask;
    assign busy     = (state_q != S_IDLE) || (pend_q != CMD_NONE)
                      || !init_done_q;
    assign cmd_wr   = wr_go && s_axi_awaddr_in == REG_CMD
                      && s_axi_wstrb_in[0] && !busy && sw_cmd != CMD_NONE;
    assign step_end = (step_q == 3'h0);
    assign take_wd  = ce_in && state_q == S_IDLE && pend_q == CMD_WRITE
                      && init_done_q;

    // Write response channel
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (ce_in) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= reg_hit_w ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Software registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            addr_q <= 32'h0;
            part_q <= PART_RST;
            pend_q <= CMD_NONE;
        end else if (ce_in) begin
            if (wr_go && s_axi_awaddr_in == REG_ADDR) begin
                addr_q <= s_axi_wdata_in;
            end
            if (wr_go && s_axi_awaddr_in == REG_PART) begin
                part_q <= s_axi_wdata_in[4:0];
            end
            if (cmd_wr && !tap_bad) begin
                pend_q <= sw_cmd;
            end else if (state_q == S_IDLE && init_done_q
                         && (pend_q != CMD_WRITE || buf_out_valid)) begin
                pend_q <= CMD_NONE;
            end
        end
    end

    // Sticky tap error; a new refusal beats the clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tap_err_q <= 1'b0;
        end else if (ce_in) begin
            if (cmd_wr && tap_bad) begin
                tap_err_q <= 1'b1;
            end else if (wr_go && s_axi_awaddr_in == REG_STATUS
                         && s_axi_wdata_in[ST_TAPERR]) begin
                tap_err_q <= 1'b0;
            end
        end
    end

    // Read channel; reading RDATA consumes the read flag
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OKAY;
        end else if (ce_in) begin
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rresp_q  <= reg_hit_r ? RESP_OKAY : RESP_DECERR;
                case (s_axi_araddr_in)
                    REG_CMD:    rdata_q <= {29'h0, cmd_q};
                    REG_ADDR:   rdata_q <= addr_q;
                    REG_STATUS: rdata_q <= {27'h0, rvalid_flag_q, tap_err_q,
                                            stop_q, init_done_q, busy};
                    REG_RDATA:  rdata_q <= {16'h0, rd_q};
                    REG_PART:   rdata_q <= {27'h0, part_q};
                    default:    rdata_q <= 32'h0;
                endcase
            end else if (s_axi_rready_in) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Data pins pass three flops; sample once the last two agree
    always_ff @(posedge ref_clk_in) begin
        if (ce_in) begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
        end
    end

    // Sequencer: power-up, init refreshes, serial init, then commands
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q     <= S_PWR;
            cmd_q       <= CMD_NONE;
            pwr_q       <= 14'(PWRUP_CYCLES - 1);
            step_q      <= 3'h0;
            ref_cnt_q   <= 4'h0;
            init_ph_q   <= 2'h0;
            init_done_q <= 1'b0;
            sclk_cnt_q  <= 1'b0;
            wd_q        <= 16'h0;
        end else if (ce_in) begin
            if (!step_end) begin
                step_q <= step_q - 3'h1;
            end
            case (state_q)
                S_PWR: begin
                    if (pwr_q == 14'h0) begin
                        state_q <= S_IDLE;
                    end else begin
                        pwr_q <= pwr_q - 14'h1;
                    end
                end
                S_IDLE: begin
                    step_q <= 3'(STEP_CYC - 1);
                    if (!init_done_q) begin
                        case (init_ph_q)
                            2'h0: begin
                                cmd_q   <= CMD_CBR;
                                state_q <= S_CBRC;
                                ref_cnt_q <= ref_cnt_q + 4'h1;
                                if (ref_cnt_q == 4'(INIT_REFRESH - 1)) begin
                                    init_ph_q <= 2'h1;
                                end
                            end
                            2'h1: begin
                                cmd_q     <= CMD_FULLX;
                                state_q   <= S_ADDR;
                                init_ph_q <= 2'h2;
                            end
                            2'h2: begin
                                state_q   <= S_SCLK;
                                init_ph_q <= 2'h3;
                            end
                            default: begin
                                init_done_q <= 1'b1;
                                if (part_q[PART_AUTO]) begin
                                    cmd_q   <= CMD_SETUP;
                                    state_q <= S_CBRC;
                                end
                            end
                        endcase
                    end else if (pend_q == CMD_CBR || pend_q == CMD_SETUP) begin
                        cmd_q   <= pend_q;
                        state_q <= S_CBRC;
                    end else if (pend_q == CMD_WRITE) begin
                        if (buf_out_valid) begin
                            cmd_q   <= pend_q;
                            wd_q    <= buf_out_data;
                            state_q <= S_ADDR;
                        end
                    end else if (pend_q != CMD_NONE) begin
                        cmd_q   <= pend_q;
                        state_q <= S_ADDR;
                    end
                end
                S_ADDR, S_CBRC: begin
                    if (step_end) begin
                        state_q <= S_ROW;
                        step_q  <= 3'(STEP_CYC - 1);
                    end
                end
                S_ROW: begin
                    if (step_end) begin
                        state_q <= (cmd_q inside {CMD_CBR, CMD_SETUP,
                                    CMD_RASREF}) ? S_PRE : S_COL;
                        step_q  <= 3'(STEP_CYC - 1);
                    end
                end
                S_COL: begin
                    // Reads hold here until the sampled data settles
                    if (step_end && (cmd_q != CMD_READ
                                     || dq_s2_q == dq_s3_q)) begin
                        state_q <= S_PRE;
                        step_q  <= 3'(STEP_CYC - 1);
                    end
                end
                S_PRE: begin
                    if (step_end) begin
                        state_q <= S_IDLE;
                    end
                end
                S_SCLK: begin
                    if (step_end) begin
                        step_q     <= 3'(STEP_CYC - 1);
                        sclk_cnt_q <= ~sclk_cnt_q;
                        if (sclk_cnt_q == 1'(INIT_SCLK - 1)) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Mirror of the device's stop-point mode
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            stop_q <= 1'b0;
        end else if (ce_in && state_q == S_ROW && step_end) begin
            if (cmd_q == CMD_SETUP) begin
                stop_q <= 1'b1;
            end else if (cmd_q == CMD_CBR) begin
                stop_q <= 1'b0;
            end
        end
    end

    // Read data capture; a fresh sample beats the read clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_q          <= 16'h0;
            rvalid_flag_q <= 1'b0;
        end else if (ce_in) begin
            if (state_q == S_COL && cmd_q == CMD_READ && step_end
                && dq_s2_q == dq_s3_q) begin
                rd_q          <= dq_s3_q;
                rvalid_flag_q <= 1'b1;
            end else if (rd_go && s_axi_araddr_in == REG_RDATA) begin
                rvalid_flag_q <= 1'b0;
            end
        end
    end

    // Pin pattern per state, registered so pins never glitch
    always_comb begin
        pins_d = '{ras_n: 1'b1, cas_n: 1'b1, write_strobes_n: 2'h3,
                   special_function_select: 1'b0,
                   transfer_output_enable_n: 1'b1, serial_clock: 1'b0,
                   addr: 9'h0};
        dq_oe_n_d = 1'b1;
        case (state_q)
            S_CBRC, S_ADDR, S_ROW: begin
                pins_d.ras_n = (state_q != S_ROW);
                if (cmd_q == CMD_SETUP) begin
                    pins_d.cas_n = 1'b0;
                    pins_d.write_strobes_n = 2'h0;
                    pins_d.special_function_select = 1'b1;
                    pins_d.addr = {1'b0, part_q[3:0], 4'h0};
                end else if (cmd_q == CMD_CBR) begin
                    pins_d.cas_n = 1'b0;
                end else begin
                    pins_d.addr = addr_q[8:0];
                    if (cmd_q == CMD_FULLX || cmd_q == CMD_SPLITX) begin
                        pins_d.transfer_output_enable_n = 1'b0;
                        pins_d.special_function_select =
                            (cmd_q == CMD_SPLITX);
                    end
                end
            end
            S_COL: begin
                pins_d.ras_n = 1'b0;
                pins_d.cas_n = 1'b0;
                pins_d.addr  = col_map(addr_q[ADDR_COL_LSB +: 9],
                                       stop_q);
                if (cmd_q == CMD_READ) begin
                    pins_d.transfer_output_enable_n = 1'b0;
                end else if (cmd_q == CMD_WRITE) begin
                    pins_d.write_strobes_n = 2'h0;
                    dq_oe_n_d = 1'b0;
                end
            end
            S_SCLK: pins_d.serial_clock = (step_q >= 3'(STEP_CYC / 2));
            default: ;
        endcase
    end

    // Output registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pins_q    <= '{ras_n: 1'b1, cas_n: 1'b1, write_strobes_n: 2'h3,
                           special_function_select: 1'b0,
                           transfer_output_enable_n: 1'b1,
                           serial_clock: 1'b0, addr: 9'h0};
            dq_oe_n_q <= 1'b1;
        end else if (ce_in) begin
            pins_q    <= pins_d;
            dq_oe_n_q <= dq_oe_n_d;
        end
    end

    assign dram_pins_out = pins_q;
    assign dq_oe_n_out   = dq_oe_n_q;
    assign dq_out        = wd_q;
endmodule

// file: vsp_checker.sv
// Pin and bus assertions of the stop-point controller
`timescale 1ns/1ps
module vsp_checker #(
    parameter int PWRUP_CYCLES = 20
) (
    input wire logic               ref_clk_in,
    input wire logic               rst_in,
    input wire vsp_pkg::vsp_pins_t dram_pins_out,
    input wire logic               dq_oe_n_out,
    input wire logic               s_axi_bvalid_out,
    input wire logic               s_axi_bready_in,
    input wire logic               s_axi_rvalid_out,
    input wire logic               s_axi_rready_in,
    input wire logic [31:0]        s_axi_rdata_out
);
    import vsp_pkg::*;
    vsp_pins_t   p;
    int unsigned up_q;
    assign p = dram_pins_out;
    // Saturating count of cycles since reset release
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) up_q <= 0;
        else if (up_q < PWRUP_CYCLES) up_q <= up_q + 1;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    chk_pwrup_quiet: assert property (up_q < PWRUP_CYCLES - 1
        |-> p.ras_n && p.cas_n) else $error("strobe during power-up wait");
    chk_setup_strobes: assert property ($fell(p.ras_n) && !p.cas_n
        && p.special_function_select |-> p.write_strobes_n == 2'b00)
        else $error("setup cycle without write strobes low");
    chk_split_marks: assert property ($fell(p.ras_n) && p.cas_n
        && p.special_function_select |-> !p.transfer_output_enable_n)
        else $error("select high at row strobe without transfer");
    chk_cbr_lead: assert property ($fell(p.cas_n) && p.ras_n
        |-> p.ras_n[*4] ##1 !p.ras_n) else $error("refresh lead wrong");
    chk_sclk_pulse: assert property ($rose(p.serial_clock)
        |=> p.serial_clock ##1 !p.serial_clock[*2])
        else $error("serial clock pulse shape wrong");
    chk_dq_off: assert property (!dq_oe_n_out
        |-> p.transfer_output_enable_n && !p.cas_n)
        else $error("data driven while device outputs enabled");
    chk_bresp_hold: assert property (s_axi_bvalid_out
        && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data changed before taken");
endmodule

// file: vsp_dram_model.sv
// Behavioural video DRAM with stop-point mode and column swap
`timescale 1ns/1ps
module vsp_dram_model (
    input wire vsp_pkg::vsp_pins_t pins_in,
    input wire logic [15:0]        dq_in,
    output logic [15:0]            dq_out,
    output logic                   stop_out,
    output logic [3:0]             code_out,
    output logic [8:0]             col_out
);
    import vsp_pkg::*;
    logic [15:0] mem [logic [17:0]];
    logic [8:0]  row_q;
    logic [15:0] rd_q = 16'h0000;
    logic        xfer_q = 1'b0;
    logic        drv;
    // No mode until a setup cycle has been seen
    initial stop_out = 1'b0;
    // Row strobe fall: setup, option reset or row latch
    always @(negedge pins_in.ras_n) begin
        if (!pins_in.cas_n) begin
            stop_out = pins_in.special_function_select
                && pins_in.write_strobes_n == 2'b00;
            if (stop_out) code_out = pins_in.addr[7:4];
        end else begin
            row_q = pins_in.addr;
            xfer_q = !pins_in.transfer_output_enable_n;
        end
    end
    // Column latch; 1 ns late so the same-edge pin updates settle first
    always @(negedge pins_in.cas_n) begin
        #1;
        if (!pins_in.ras_n) begin
            col_out = stop_out ? {pins_in.addr[7], pins_in.addr[8],
                pins_in.addr[6:0]} : pins_in.addr;
            if (pins_in.write_strobes_n == 2'b00) mem[{row_q, col_out}] = dq_in;
            else if (!xfer_q) rd_q = mem[{row_q, col_out}];
        end
    end
    // Outputs off in write and transfer cycles; released lines invert
    assign drv = !pins_in.ras_n && !pins_in.cas_n && !xfer_q
        && !pins_in.transfer_output_enable_n
        && pins_in.write_strobes_n == 2'b11;
    assign dq_out = drv ? rd_q : ~rd_q;
endmodule

// file: tb.sv
// Self-checking bench of the stop-point controller with a device model
`timescale 1ns/1ps
module tb;
    import vsp_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, rd_v, seed = 32'h41bff319;
    logic        awr, wrr, bv, arr, rv, oe_n, stop;
    logic [15:0] dq, dq_o, dev_dq;
    logic [3:0]  code;
    logic [8:0]  col;
    logic [1:0]  rrsp;
    vsp_pins_t   pins;
    int          errors = 0, checked = 0;
    assign dq = oe_n ? dev_dq : dq_o;
    vsp_ctrl #(.PWRUP_CYCLES(20)) i_dut (.ref_clk_in(clk), .rst_in(rst),
        .ce_in(1'b1), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_bresp_out(), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rrsp),
        .dram_pins_out(pins), .dq_in(dq), .dq_out(dq_o), .dq_oe_n_out(oe_n));
    vsp_dram_model i_dev (.pins_in(pins), .dq_in(dq), .dq_out(dev_dq),
        .stop_out(stop), .code_out(code), .col_out(col));
    initial forever #10 clk = ~clk;
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [6:0] msk(input logic [3:0] c);
        return (c > 4'h5) ? 7'h7f : 7'((2 << c) - 1);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awv, wv, awa, wd, br} <= {2'b11, a, d, 1'b1};
        do @(posedge clk); while (awr !== 1'b1);
        {awv, wv} <= 2'b00;
        do @(posedge clk); while (bv !== 1'b1);
        br <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {arv, ara, rr} <= {1'b1, a, 1'b1};
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rdat;
        rr <= 1'b0;
    endtask
    // Busy is polled, since command length depends on read sync delay
    task automatic cmd(input vsp_cmd_t c);
        if (c != CMD_NONE) wr(REG_CMD, 32'(c));
        do rd(REG_STATUS, rd_v); while (rd_v[ST_BUSY] !== 1'b0);
    endtask
    // Random word through a write and a read, column swap checked
    task automatic rw(input logic s);
        logic [8:0] c;
        seed = nx(seed);
        c = seed[24:16];
        wr(REG_WDATA, seed);
        wr(REG_ADDR, {7'h0, c, 7'h0, seed[8:0]});
        cmd(CMD_WRITE);
        chk(32'({stop, col}), 32'({s, c}));
        cmd(CMD_READ);
        rd(REG_RDATA, rd_v);
        chk(rd_v & 32'hffff, seed & 32'hffff);
    endtask
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("ERROR %0t: timeout", $time);
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        cmd(CMD_NONE);
        chk(rd_v & 32'h7, 32'h6);
        chk(32'(code), 32'(PART_RST[3:0]));
        repeat (3) rw(1'b1);
        // Two words queued before either write command drains them
        for (int k = 0; k < 2; k++) wr(REG_WDATA, 32'ha5c0 + k);
        for (int k = 0; k < 4; k++) begin
            wr(REG_ADDR, 32'(k % 2));
            cmd(k < 2 ? CMD_WRITE : CMD_READ);
            rd(REG_RDATA, rd_v);
            if (k > 1) chk(rd_v & 32'hffff, 32'ha5c0 + k - 2);
        end
        for (int k = 0; k < 4; k++) begin
            cmd(k[0] ? CMD_RASREF : CMD_CBR);
            chk(32'(stop) + 32'(rd_v[ST_STOP]), 32'h0);
        end
        cmd(CMD_FULLX);
        rw(1'b0);
        seed = nx(seed);
        wr(REG_PART, {27'h0, 1'b1, seed[3:0]});
        cmd(CMD_SETUP);
        chk({code, 3'h0, stop}, {seed[3:0], 4'h1});
        wr(REG_ADDR, {9'h0, msk(seed[3:0]), 16'h0});
        cmd(CMD_SPLITX);
        chk(32'(rd_v[ST_TAPERR]), 32'h1);
        wr(REG_STATUS, 32'h8);
        wr(REG_ADDR, 32'h0100_0000);
        cmd(CMD_SPLITX);
        chk(32'({rd_v[ST_TAPERR], col}), 32'h100);
        rd(8'h18, rd_v);
        chk({rrsp, rd_v[29:0]}, {RESP_DECERR, 30'h0});
        rw(1'b1);
        wrap_up();
    end
endmodule
bind vsp_ctrl vsp_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .dram_pins_out(dram_pins_out),
    .dq_oe_n_out(dq_oe_n_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out));
